// ### shared/charge_path_map.svh
/*
 * Timing, level and reset constants of the charge path and boost sequencer.
 * Assumes inclusion by bare name from the design file; the package does not include it.
 */
`ifndef CHARGE_PATH_MAP_SVH
`define CHARGE_PATH_MAP_SVH

// ----------------------------------------
// Clock and timebase
// ----------------------------------------
`define CLK_HZ            25000000
`define TICK_PER_SEC      1000
`define TICK_CYCLES       (`CLK_HZ / `TICK_PER_SEC)

// ----------------------------------------
// Waits and safety timers
// ----------------------------------------
`define INPUT_WAIT_SEC    2
`define BOOST_RETRY_SEC   2
`define PRE_TIMEOUT_MIN   60
`define FAST_TIMEOUT_MIN  780
`define SEC_PER_MIN       60
`define BLINK_HZ_X100     75
`define BLINK_HALF_TICKS  ((`TICK_PER_SEC * 100) / (2 * `BLINK_HZ_X100))

// ----------------------------------------
// Current command and switch drive
// ----------------------------------------
`define CUR_ZERO          8'h00
`define CUR_STEP          8'h01
`define CUR_PRE           8'h1A
`define CUR_FULL          8'hFF
`define DRIVE_OFF         4'h0
`define DRIVE_LINEAR      4'h8
`define DRIVE_FULL        4'hF
`define DRIVE_STEP        4'h1
`define CNT_ZERO          32'h0000_0000
`define CNT_STEP          32'h0000_0001

`endif

// ### shared/charge_path_pkg.sv
/*
 * Types shared by the charge path and boost sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package charge_path_pkg;

    // ----------------------------------------
    // Sequencer states and charge phases
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_OFF, ST_WAIT, ST_SOFT, ST_CHARGE, ST_DONE, ST_FAULT,
        ST_BOOST, ST_BOOST_OVP, ST_BOOST_OFF
    } seq_state_e;

    typedef enum logic [1:0] {
        PH_IDLE, PH_PRE, PH_CC, PH_CV
    } charge_phase_e;

endpackage

`default_nettype wire

// ### logic/charge_path_boost_sequencer.sv
/*
 * Charge path and reverse boost sequencer: power-up, power path, charge
 * phases, input load limiting, safety timers, boost control, status pin.
 * Assumes asynchronous comparator flags and host pins, one 25 MHz clock and
 * analog loops that act on the mode outputs.
 */
// Function
// - Input valid needs undervoltage flag and above-battery.
// - Wait two seconds before system soft start.
// - Charge after soft start, current ramps up.
// - Disable input high turns the device off.
// - No input, battery healthy: battery switch closed.
// - Battery below 3.3V: linear switch, 3.6V rail.
// - Above minimum: switch ramps on, 300mV tracking.
// - Input under limit lowers charge current command.
// - System below battery enters supplement mode.
// - Battery below depletion leaves supplement mode.
// - New cycle starts in precondition phase.
// - Precondition threshold moves to constant current.
// - Regulation voltage moves to constant voltage.
// - Termination opens switch, converter keeps running.
// - Below recharge restarts at constant current.
// - Boost only when all enabling conditions hold; while boosting, the code rechecks only request, overvoltage, undervoltage and disable.
// - Boost overvoltage stops switching.
// - Boost undervoltage: off two seconds, retry.
// - Status shows charging, done, disabled, fault.
// - Status low, high, or 0.75Hz blink.
// - Safety timeouts fault; input removal clears.
`timescale 1ns/1ps
`default_nettype none
`include "charge_path_map.svh"

module charge_path_boost_sequencer #(
    parameter int unsigned TICK_CYCLES  = `TICK_CYCLES,
    parameter int unsigned WAIT_TICKS   = `INPUT_WAIT_SEC * `TICK_PER_SEC,
    parameter int unsigned RETRY_TICKS  = `BOOST_RETRY_SEC * `TICK_PER_SEC,
    parameter int unsigned PRE_TICKS    = `PRE_TIMEOUT_MIN * `SEC_PER_MIN * `TICK_PER_SEC,
    parameter int unsigned FAST_TICKS   = `FAST_TIMEOUT_MIN * `SEC_PER_MIN * `TICK_PER_SEC,
    parameter int unsigned BLINK_TICKS  = `BLINK_HALF_TICKS
) (
    input  wire logic                           ref_clk,
    input  wire logic                           sys_rst,
    input  wire logic                           inputUvloOk,
    input  wire logic                           inputAboveBat,
    input  wire logic                           batAboveDepletion,
    input  wire logic                           batAboveMinSys,
    input  wire logic                           batAbovePrecond,
    input  wire logic                           batAtRegulation,
    input  wire logic                           batAboveRecharge,
    input  wire logic                           batAboveBoostUv,
    input  wire logic                           inputBelowLimit,
    input  wire logic                           sysBelowBat,
    input  wire logic                           currentBelowTerm,
    input  wire logic                           inputBelowBatPlus50,
    input  wire logic                           boostOutputOvervoltage,
    input  wire logic                           boostOutputUndervoltage,
    input  wire logic                           tempSenseFault,
    input  wire logic                           softStartDone,
    input  wire logic                           disableInput,
    input  wire logic                           boostRequest,
    output var  logic                           buckEnable,
    output var  logic                           softStartEnable,
    output var  logic                           batterySwitchOn,
    output var  logic                           batterySwitchLinear,
    output var  logic                           sysTrackBattery,
    output var  logic [3:0]                     batterySwitchDrive,
    output var  charge_path_pkg::charge_phase_e chargePhase,
    output var  logic [7:0]                     chargeCurrentCmd,
    output var  logic                           boostEnable,
    output var  logic                           supplementMode,
    output var  logic                           timerFault,
    output var  logic                           statusOut,
    output var  logic                           statusOe
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [17:0] syncA_reg;
    logic [17:0] syncB_reg;
    logic        inUvlo, inAboveBat, batDpl, batMinSys, batPre, batReg, batRech, batBstUv;
    logic        inLimit, sysLow, curTerm, inBelow50, bstOv, bstUv, tempFault, softDone;
    logic        disabled, bstReq;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            syncA_reg <= '0;
            syncB_reg <= '0;
        end else begin
            syncA_reg <= {inputUvloOk, inputAboveBat, batAboveDepletion, batAboveMinSys,
                          batAbovePrecond, batAtRegulation, batAboveRecharge, batAboveBoostUv,
                          inputBelowLimit, sysBelowBat, currentBelowTerm, inputBelowBatPlus50,
                          boostOutputOvervoltage, boostOutputUndervoltage, tempSenseFault,
                          softStartDone, disableInput, boostRequest};
            syncB_reg <= syncA_reg;
        end
    end

    assign {inUvlo, inAboveBat, batDpl, batMinSys, batPre, batReg, batRech, batBstUv,
            inLimit, sysLow, curTerm, inBelow50, bstOv, bstUv, tempFault, softDone,
            disabled, bstReq} = syncB_reg;

    // ----------------------------------------
    // Timebase and timers
    // ----------------------------------------
    logic [31:0] tickCnt_reg, waitCnt_reg, safeCnt_reg, blinkCnt_reg;
    logic        blink_reg, tick, waitDone, retryDone, preTimeout, fastTimeout;

    charge_path_pkg::seq_state_e    state_reg, state_next;
    charge_path_pkg::charge_phase_e phase_reg, phase_next;

    assign tick        = (tickCnt_reg == 32'(TICK_CYCLES - 1));
    assign waitDone    = (waitCnt_reg >= 32'(WAIT_TICKS));
    assign retryDone   = (waitCnt_reg >= 32'(RETRY_TICKS));
    assign preTimeout  = (phase_reg == charge_path_pkg::PH_PRE) && (safeCnt_reg >= 32'(PRE_TICKS));
    assign fastTimeout = (phase_reg == charge_path_pkg::PH_CC || phase_reg == charge_path_pkg::PH_CV)
                         && (safeCnt_reg >= 32'(FAST_TICKS));

    always_ff @(posedge ref_clk) begin
        if (sys_rst || tick) begin
            tickCnt_reg <= `CNT_ZERO;
        end else begin
            tickCnt_reg <= tickCnt_reg + `CNT_STEP;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || state_next != state_reg) begin
            waitCnt_reg <= `CNT_ZERO;
        end else if (tick) begin
            waitCnt_reg <= waitCnt_reg + `CNT_STEP;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || phase_next != phase_reg) begin
            safeCnt_reg <= `CNT_ZERO;
        end else if (tick && phase_reg != charge_path_pkg::PH_IDLE && !tempFault) begin
            safeCnt_reg <= safeCnt_reg + `CNT_STEP;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            blinkCnt_reg <= `CNT_ZERO;
            blink_reg    <= 1'b0;
        end else if (tick && blinkCnt_reg >= 32'(BLINK_TICKS - 1)) begin
            blinkCnt_reg <= `CNT_ZERO;
            blink_reg    <= !blink_reg;
        end else if (tick) begin
            blinkCnt_reg <= blinkCnt_reg + `CNT_STEP;
        end
    end

    // ----------------------------------------
    // Sequencer decode
    // ----------------------------------------
    logic inputOk, boostAllowed, inputState, termReady;

    assign inputOk      = inUvlo && inAboveBat;
    assign boostAllowed = batBstUv && inBelow50 && bstReq && !tempFault && !bstOv;
    assign inputState   = (state_reg == charge_path_pkg::ST_WAIT) || (state_reg == charge_path_pkg::ST_SOFT)
                          || (state_reg == charge_path_pkg::ST_CHARGE) || (state_reg == charge_path_pkg::ST_DONE)
                          || (state_reg == charge_path_pkg::ST_FAULT);
    assign termReady    = batRech && curTerm;

    always_comb begin
        state_next = state_reg;
        phase_next = phase_reg;
        case (state_reg)
            charge_path_pkg::ST_OFF: begin
                if (inputOk) begin
                    state_next = charge_path_pkg::ST_WAIT;
                end else if (boostAllowed) begin
                    state_next = charge_path_pkg::ST_BOOST;
                end
            end
            charge_path_pkg::ST_WAIT: begin
                if (waitDone) begin
                    state_next = charge_path_pkg::ST_SOFT;
                end
            end
            charge_path_pkg::ST_SOFT: begin
                if (softDone) begin
                    state_next = charge_path_pkg::ST_CHARGE;
                    phase_next = charge_path_pkg::PH_PRE;
                end
            end
            charge_path_pkg::ST_CHARGE: begin
                if (preTimeout || fastTimeout) begin
                    state_next = charge_path_pkg::ST_FAULT;
                    phase_next = charge_path_pkg::PH_IDLE;
                end else if (phase_reg == charge_path_pkg::PH_PRE && batPre) begin
                    phase_next = charge_path_pkg::PH_CC;
                end else if (phase_reg == charge_path_pkg::PH_CC && batReg) begin
                    phase_next = charge_path_pkg::PH_CV;
                end else if (phase_reg == charge_path_pkg::PH_CV && termReady) begin
                    state_next = charge_path_pkg::ST_DONE;
                    phase_next = charge_path_pkg::PH_IDLE;
                end
            end
            charge_path_pkg::ST_DONE: begin
                if (!batRech) begin
                    state_next = charge_path_pkg::ST_CHARGE;
                    phase_next = charge_path_pkg::PH_CC;
                end
            end
            charge_path_pkg::ST_FAULT: begin
                state_next = charge_path_pkg::ST_FAULT;
            end
            charge_path_pkg::ST_BOOST: begin
                if (!bstReq) begin
                    state_next = charge_path_pkg::ST_OFF;
                end else if (bstOv) begin
                    state_next = charge_path_pkg::ST_BOOST_OVP;
                end else if (bstUv) begin
                    state_next = charge_path_pkg::ST_BOOST_OFF;
                end
            end
            charge_path_pkg::ST_BOOST_OVP: begin
                if (!bstOv || !bstReq) begin
                    state_next = charge_path_pkg::ST_OFF;
                end
            end
            charge_path_pkg::ST_BOOST_OFF: begin
                if (retryDone) begin
                    state_next = boostAllowed ? charge_path_pkg::ST_BOOST : charge_path_pkg::ST_OFF;
                end
            end
            default: begin
                state_next = charge_path_pkg::ST_OFF;
                phase_next = charge_path_pkg::PH_IDLE;
            end
        endcase
        if (disabled || (inputState && !inputOk)) begin
            state_next = charge_path_pkg::ST_OFF;
            phase_next = charge_path_pkg::PH_IDLE;
        end
    end

    // ----------------------------------------
    // Power path and current decode
    // ----------------------------------------
    logic       buckOn, boostState, supp_next, battOn_next, charging_next, fault_next;
    logic [7:0] curTarget, cur_next;
    logic [3:0] drive_next;

    assign buckOn        = (state_next == charge_path_pkg::ST_SOFT) || (state_next == charge_path_pkg::ST_CHARGE)
                           || (state_next == charge_path_pkg::ST_DONE) || (state_next == charge_path_pkg::ST_FAULT);
    assign boostState    = (state_next == charge_path_pkg::ST_BOOST) || (state_next == charge_path_pkg::ST_BOOST_OVP)
                           || (state_next == charge_path_pkg::ST_BOOST_OFF);
    assign supp_next     = buckOn && batDpl && (supplementMode || sysLow);
    assign charging_next = (phase_next != charge_path_pkg::PH_IDLE);
    assign battOn_next   = ((state_next == charge_path_pkg::ST_OFF) && batDpl)
                           || charging_next || supp_next || boostState;
    assign fault_next    = (state_next == charge_path_pkg::ST_FAULT) || (charging_next && tempFault);
    assign curTarget     = (phase_reg == charge_path_pkg::PH_PRE) ? `CUR_PRE : `CUR_FULL;

    assign cur_next   = (phase_reg == charge_path_pkg::PH_IDLE || tempFault) ? `CUR_ZERO
                      : (chargeCurrentCmd > curTarget) ? curTarget
                      : !tick ? chargeCurrentCmd
                      : (inLimit && chargeCurrentCmd != `CUR_ZERO) ? chargeCurrentCmd - `CUR_STEP
                      : (!inLimit && chargeCurrentCmd < curTarget) ? chargeCurrentCmd + `CUR_STEP
                      : chargeCurrentCmd;

    assign drive_next = !battOn_next ? `DRIVE_OFF
                      : !batMinSys ? `DRIVE_LINEAR
                      : (tick && batterySwitchDrive != `DRIVE_FULL) ? batterySwitchDrive + `DRIVE_STEP
                      : batterySwitchDrive;

    // ----------------------------------------
    // Registers and outputs
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg           <= charge_path_pkg::ST_OFF;
            phase_reg           <= charge_path_pkg::PH_IDLE;
            buckEnable          <= 1'b0;
            softStartEnable     <= 1'b0;
            batterySwitchOn     <= 1'b0;
            batterySwitchLinear <= 1'b0;
            sysTrackBattery     <= 1'b0;
            batterySwitchDrive  <= `DRIVE_OFF;
            chargePhase         <= charge_path_pkg::PH_IDLE;
            chargeCurrentCmd    <= `CUR_ZERO;
            boostEnable         <= 1'b0;
            supplementMode      <= 1'b0;
            timerFault          <= 1'b0;
            statusOut           <= 1'b0;
            statusOe            <= 1'b0;
        end else begin
            state_reg           <= state_next;
            phase_reg           <= phase_next;
            buckEnable          <= buckOn;
            softStartEnable     <= (state_next == charge_path_pkg::ST_SOFT);
            batterySwitchOn     <= battOn_next;
            batterySwitchLinear <= battOn_next && !batMinSys;
            sysTrackBattery     <= battOn_next && batMinSys;
            batterySwitchDrive  <= drive_next;
            chargePhase         <= phase_next;
            chargeCurrentCmd    <= cur_next;
            boostEnable         <= (state_next == charge_path_pkg::ST_BOOST);
            supplementMode      <= supp_next;
            timerFault          <= (state_next == charge_path_pkg::ST_FAULT);
            statusOut           <= 1'b0;
            statusOe            <= fault_next ? blink_reg : (charging_next || supp_next);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    AST_INPUT_QUAL: assert property (
        (state_reg == charge_path_pkg::ST_OFF && !inputOk) |=> state_reg != charge_path_pkg::ST_WAIT)
        else $error("Sequencer started on an unqualified input");
    AST_WAIT_TIME: assert property (
        (state_reg == charge_path_pkg::ST_WAIT && !waitDone) |=> state_reg != charge_path_pkg::ST_SOFT)
        else $error("Soft start began before the input wait");
    AST_SOFT_FIRST: assert property (
        ($past(phase_reg) == charge_path_pkg::PH_IDLE && phase_reg == charge_path_pkg::PH_PRE)
        |-> $past(state_reg) == charge_path_pkg::ST_SOFT)
        else $error("Precondition began without soft start");
    AST_CMD_RAMP: assert property (
        (chargeCurrentCmd > $past(chargeCurrentCmd)) |-> chargeCurrentCmd == $past(chargeCurrentCmd) + `CUR_STEP)
        else $error("Charge current stepped instead of ramping");
    AST_DISABLE: assert property (
        disabled |=> state_reg == charge_path_pkg::ST_OFF && !buckEnable && !boostEnable)
        else $error("Device active while disabled");
    AST_DPM: assert property (
        (inLimit && tick && phase_reg != charge_path_pkg::PH_IDLE && !tempFault
         && chargeCurrentCmd != `CUR_ZERO && chargeCurrentCmd <= curTarget)
        |=> chargeCurrentCmd == $past(chargeCurrentCmd) - `CUR_STEP)
        else $error("Current command not lowered under input limit");
    AST_SUPP_EXIT: assert property (
        (supplementMode && !batDpl) |=> !supplementMode)
        else $error("Supplement mode kept below depletion");
    AST_EOC_SWITCH: assert property (
        (state_reg == charge_path_pkg::ST_DONE) |-> buckEnable && (!batterySwitchOn || supplementMode))
        else $error("Switch not opened after termination");
    AST_RECHARGE_CC: assert property (
        (state_reg == charge_path_pkg::ST_DONE && !batRech && inputOk && !disabled)
        |=> phase_reg == charge_path_pkg::PH_CC)
        else $error("Recharge did not restart in constant current");
    AST_BOOST_GATE: assert property (
        $rose(boostEnable) |-> $past(boostAllowed))
        else $error("Boost enabled without its conditions");
    AST_BOOST_OVP: assert property (
        (state_reg == charge_path_pkg::ST_BOOST && bstOv) |=> !boostEnable ##1 !boostEnable)
        else $error("Boost kept switching in overvoltage");

    COV_FULL_CYCLE: cover property (
        state_reg == charge_path_pkg::ST_CHARGE ##1 state_reg == charge_path_pkg::ST_DONE);
    COV_BOOST_RETRY: cover property (
        state_reg == charge_path_pkg::ST_BOOST_OFF ##1 state_reg == charge_path_pkg::ST_BOOST);
    COV_SUPPLEMENT: cover property ($rose(supplementMode));
    COV_TIMER_FAULT: cover property ($rose(timerFault));

endmodule

`default_nettype wire

// ### bench/power_stage_model.sv
/* Battery comparator model: flags from a coarse battery level 0..4.
 * Assumes the bench sets the level; thresholds stay ordered. */
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
    input  wire logic [2:0] batLevel,
    output var  logic       batAboveDepletion,
    output var  logic       batAboveBoostUv,
    output var  logic       batAboveMinSys,
    output var  logic       batAbovePrecond,
    output var  logic       batAboveRecharge,
    output var  logic       batAtRegulation
);
    // ----------------------------------------
    // Ordered thresholds
    // ----------------------------------------
    assign batAboveDepletion = batLevel >= 3'h1;
    assign batAboveBoostUv   = batLevel >= 3'h1;
    assign batAboveMinSys    = batLevel >= 3'h2;
    assign batAbovePrecond   = batLevel >= 3'h2;
    assign batAboveRecharge  = batLevel >= 3'h3;
    assign batAtRegulation   = batLevel >= 3'h4;
endmodule
`default_nettype wire

// ### bench/charge_path_boost_sequencer_tb.sv
/* Sequencer bench: charge flow, disable, timer fault, boost retry.
 * Assumes short timing parameters and the battery model. */
`timescale 1ns/1ps
`default_nettype none
module charge_path_boost_sequencer_tb;
    logic ref_clk = 1'b0, sys_rst = 1'b1, uv = 1'b0, aboveBat = 1'b0, lim = 1'b0, sysLow = 1'b0;
    logic term = 1'b0, b50 = 1'b0, ov = 1'b0, und = 1'b0, temp = 1'b0, ssd = 1'b0, dis = 1'b0, req = 1'b0;
    logic [2:0] lvl = 3'h1;
    wire dep, buv, mins, pre, rech, atReg;
    wire [7:0] cur;
    wire [3:0] drv;
    charge_path_pkg::charge_phase_e ph;
    wire buck, ss, sw, lin, trk, boost, supp, tf, so, soe;
    int fail_count = 0, cmp_count = 0;
    power_stage_model i_bat (.batLevel(lvl), .batAboveDepletion(dep), .batAboveBoostUv(buv),
        .batAboveMinSys(mins), .batAbovePrecond(pre), .batAboveRecharge(rech), .batAtRegulation(atReg));
    charge_path_boost_sequencer #(.TICK_CYCLES(4), .WAIT_TICKS(5), .RETRY_TICKS(5), .PRE_TICKS(20),
        .FAST_TICKS(40), .BLINK_TICKS(3)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .inputUvloOk(uv),
        .inputAboveBat(aboveBat), .batAboveDepletion(dep), .batAboveMinSys(mins), .batAbovePrecond(pre),
        .batAtRegulation(atReg), .batAboveRecharge(rech), .batAboveBoostUv(buv), .inputBelowLimit(lim),
        .sysBelowBat(sysLow), .currentBelowTerm(term), .inputBelowBatPlus50(b50),
        .boostOutputOvervoltage(ov), .boostOutputUndervoltage(und), .tempSenseFault(temp),
        .softStartDone(ssd), .disableInput(dis), .boostRequest(req), .buckEnable(buck),
        .softStartEnable(ss), .batterySwitchOn(sw), .batterySwitchLinear(lin), .sysTrackBattery(trk),
        .batterySwitchDrive(drv), .chargePhase(ph), .chargeCurrentCmd(cur), .boostEnable(boost),
        .supplementMode(supp), .timerFault(tf), .statusOut(so), .statusOe(soe));
    // ----------------------------------------
    // Clock, tasks, watchdog
    // ----------------------------------------
    initial forever #20 ref_clk = ~ref_clk;
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #100us;
        fail_count++;
        results();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        w(8); sys_rst = 1'b0; w(6);
        chk("swNoInput", sw, 8'h01);
        chk("statIdle", soe, 8'h00);
        chk("statOut", so, 8'h00);
        uv = 1'b1; w(6);
        chk("waitUvOnly", ss, 8'h00);
        aboveBat = 1'b1; w(8);
        chk("waitEarly", ss, 8'h00);
        w(24); chk("softStart", ss, 8'h01);
        chk("noChargeYet", 8'(ph), 8'(charge_path_pkg::PH_IDLE));
        ssd = 1'b1; w(6);
        chk("prePhase", 8'(ph), 8'(charge_path_pkg::PH_PRE));
        chk("statCharge", soe, 8'h01);
        lvl = 3'h2; w(6); chk("ccPhase", 8'(ph), 8'(charge_path_pkg::PH_CC));
        chk("track", trk, 8'h01);
        lvl = 3'h4; w(6); chk("cvPhase", 8'(ph), 8'(charge_path_pkg::PH_CV));
        term = 1'b1; w(6);
        chk("doneSw", sw, 8'h00);
        chk("doneBuck", buck, 8'h01);
        chk("doneStat", soe, 8'h00);
        lvl = 3'h2; w(6); chk("recharge", 8'(ph), 8'(charge_path_pkg::PH_CC));
        $display("charge flow done");
        dis = 1'b1; w(6);
        chk("disBuck", buck, 8'h00);
        chk("disPhase", 8'(ph), 8'(charge_path_pkg::PH_IDLE));
        $display("disable done");
        lvl = 3'h1; term = 1'b0; dis = 1'b0; w(140);
        chk("preTimeout", tf, 8'h01);
        uv = 1'b0; w(6); chk("faultClear", tf, 8'h00);
        $display("timer fault done");
        aboveBat = 1'b0; b50 = 1'b1; lvl = 3'h3; req = 1'b1; w(6);
        chk("boostOn", boost, 8'h01);
        chk("boostIdle", 8'(ph), 8'(charge_path_pkg::PH_IDLE));
        und = 1'b1; w(4); und = 1'b0; w(2);
        chk("boostOff", boost, 8'h00);
        w(40); chk("boostRetry", boost, 8'h01);
        ov = 1'b1; w(6);
        chk("boostOvp", boost, 8'h00);
        $display("boost done");
        ov = 1'b0; req = 1'b0; b50 = 1'b0; uv = 1'b1; aboveBat = 1'b1; lvl = 3'h1; w(30);
        chk("afterBoostPre", 8'(ph), 8'(charge_path_pkg::PH_PRE));
        chk("linear", lin, 8'h01);
        chk("drvLinear", drv, 8'h08);
        chk("curRamp", cur, 8'h01);
        lim = 1'b1; w(12); chk("limitCur", cur, 8'h00);
        lim = 1'b0; sysLow = 1'b1; w(6);
        chk("suppOn", supp, 8'h01);
        lvl = 3'h0; w(6); chk("suppOff", supp, 8'h00);
        $display("power path done");
        results();
    end
endmodule
`default_nettype wire
